// ### inc/scale_exchange_regs.svh
`ifndef SCALE_EXCHANGE_REGS_SVH
`define SCALE_EXCHANGE_REGS_SVH

// exchange word indices
`define WORD_VALUE        1'h0
`define WORD_CMD          1'h1
// status word bit positions
`define ST_SP1            0
`define ST_SP2            1
`define ST_ZTOL           2
`define ST_DISC_IN        9
`define ST_MOTION         12
`define ST_NET            13
`define ST_BUSY           14
`define ST_DATA_OK        15
// command word bit positions
`define CMD_SEL_LO        0
`define CMD_SEL_HI        2
`define CMD_LOAD_TARE     3
`define CMD_CLR_TARE      4
`define CMD_PB_TARE       5
`define CMD_PRINT         6
`define CMD_ZERO          7
`define CMD_ENABLE_SP     8
`define CMD_PAR_LO        12
`define CMD_PAR_HI        14
`define CMD_LOAD_SP1      15
// writable bits of the command word
`define CMD_USED_MASK     16'hF1FF
// reset values
`define RESET_WORD        16'h0000
`define RESET_FLAGS       3'h0

`endif

// ### inc/scale_exchange_pkg.sv
package scale_exchange_pkg;

    typedef enum logic [2:0] {
        src_gross,
        src_net,
        src_displayed,
        src_tare,
        src_setpoint,
        src_gross_5,
        src_gross_6,
        src_gross_7
    } weight_src_e;

    typedef enum {
        ph_idle,
        ph_write_value,
        ph_write_status
    } update_phase_e;

    // live scale measurements and conditions
    typedef struct packed {
        logic [15:0] gross;
        logic [15:0] net;
        logic [15:0] displayed;
        logic [15:0] tare;
        logic [15:0] target;
        logic        motion;
        logic        net_mode;
        logic        over_range;
        logic        under_range;
        logic        powering_up;
        logic        expanded;
        logic        setup;
        logic        over_under_mode;
        logic        indicator_mode;
        logic        interlocks;
        logic        gross_zero;
        logic        sp1_state;
        logic        sp2_state;
        logic        ztol_state;
        logic        under_state;
        logic        ok_state;
        logic        over_state;
    } scale_state_s;

    // one-cycle commands to the scale core
    typedef struct packed {
        logic        load_tare;
        logic        clear_tare;
        logic        pushbutton_tare;
        logic        print;
        logic        zero;
        logic        load_target;
        logic        commit_target;
        logic [15:0] value;
    } scale_cmd_s;

endpackage : scale_exchange_pkg

// ### hw/exchange_mem.sv
`timescale 1ns/1ns
`include "scale_exchange_regs.svh"

module exchange_mem (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // device write port
    input  wire logic        wr_en,
    input  wire logic        wr_addr,
    input  wire logic [15:0] wr_data,
    // controller read port
    input  wire logic        rd_addr,
    output logic      [15:0] rd_data
);

    logic [1:0][15:0] words;

    // two-word shared store, registered read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            words   <= '0;
            rd_data <= `RESET_WORD;
        end else begin
            if (wr_en) begin
                words[wr_addr] <= wr_data;
            end
            rd_data <= words[rd_addr];
        end
    end

endmodule : exchange_mem

// ### hw/scale_discrete_quarter_rack_exchange.sv
`timescale 1ns/1ns
`include "scale_exchange_regs.svh"
// How it works
// - refresh words at conversion rate only
// - two 16-bit words each direction
// - word 0 is signed 16-bit value
// - bit 0 setpoint one or under
// - bit 1 setpoint two or tolerance
// - bit 2 zero tolerance or over
// - bit 9 shows discrete input sampled at tick
// - bit 12 motion, bit 13 net
// - bit 14 set when read hits update
// - bit 15 set only when scale normal
// - invalid data forces weight to zero
// - select bits choose weight source
// - bit 3 rise loads preset tare
// - bits 4-7 rising edges fire commands
// - bit 8 gates high-level outputs
// - enabling setpoint commits downloaded target
// - bits 12-14 drive outputs in indicator
// - bit 15 rise loads first target
// - interlocks block accumulative tares
// - interlocks allow clear at gross zero

module scale_discrete_quarter_rack_exchange (
    // clock and reset
    input  wire logic                             mclk,
    input  wire logic                             rst_n,
    // controller exchange port
    input  wire logic                             ctl_wr,
    input  wire logic                             ctl_wr_addr,
    input  wire logic [15:0]                      ctl_wr_data,
    input  wire logic                             ctl_rd,
    input  wire logic                             ctl_rd_addr,
    output logic      [15:0]                      ctl_rd_data,
    // scale core side
    input  wire logic                             conv_tick,
    input  wire scale_exchange_pkg::scale_state_s scale,
    input  wire logic                             discrete_input_level,
    output scale_exchange_pkg::scale_cmd_s        cmd,
    output logic                                  high_outputs_enable,
    // parallel outputs
    output logic                                  parallel_output_first,
    output logic                                  parallel_output_second,
    output logic                                  parallel_output_third
);
    import scale_exchange_pkg::*;

    typedef struct packed {
        update_phase_e phase;
        logic [15:0]   value_out;
        logic [15:0]   cmd_out;
        logic [15:0]   prev_cmd;
        logic [15:0]   weight_snap;
        logic [15:0]   status_snap;
        logic          target_pending;
        logic          busy_seen;
        logic          rd_pending;
        logic          rd_busy;
        logic [15:0]   rd_data;
        scale_cmd_s    cmd;
        logic          hi_en;
        logic [2:0]    par;
    } state_s;

    state_s      state;
    state_s      next_state;
    logic        mem_wr;
    logic        mem_addr;
    logic [15:0] mem_data;
    logic [15:0] mem_rd;

    function automatic logic rose(input logic [15:0] now,
                                  input logic [15:0] was,
                                  input int          bit_pos);
        rose = now[bit_pos] & ~was[bit_pos];
    endfunction : rose

    function automatic logic [15:0] pick(input scale_state_s s,
                                         input logic [2:0]   sel);
        case (weight_src_e'(sel))
            src_net:       pick = s.net;
            src_displayed: pick = s.displayed;
            src_tare:      pick = s.over_under_mode ? s.target : s.tare;
            src_setpoint:  pick = s.target;
            default:       pick = s.gross;
        endcase
    endfunction : pick

    // interlocked tares may not stack on a standing tare
    function automatic logic tare_blocked(input scale_state_s s);
        tare_blocked = s.interlocks && (s.tare != 16'h0000);
    endfunction : tare_blocked

    // interlocked clear needs the gross weight at zero
    function automatic logic clear_allowed(input scale_state_s s);
        clear_allowed = !s.interlocks || s.gross_zero;
    endfunction : clear_allowed

    // weight word 0; invalid data reads as zero
    function automatic logic [15:0] weight_word(input scale_state_s s,
                                                input logic [2:0]   sel,
                                                input logic         ok);
        weight_word = ok ? pick(s, sel) : `RESET_WORD;
    endfunction : weight_word

    // status word 1; unused positions stay zero
    function automatic logic [15:0] status_word(input scale_state_s s,
                                                input logic         din,
                                                input logic         ok);
        logic ou;
        ou = s.over_under_mode;
        status_word = '0;
        status_word[`ST_SP1]     = ou ? s.under_state : s.sp1_state;
        status_word[`ST_SP2]     = ou ? s.ok_state : s.sp2_state;
        status_word[`ST_ZTOL]    = ou ? s.over_state : s.ztol_state;
        status_word[`ST_DISC_IN] = din;
        status_word[`ST_MOTION]  = s.motion;
        status_word[`ST_NET]     = s.net_mode;
        status_word[`ST_DATA_OK] = ok;
    endfunction : status_word

    logic data_ok;
    assign data_ok = ~(scale.over_range | scale.under_range |
                       scale.powering_up | scale.expanded | scale.setup);

    // both write beats count as an update in progress
    logic updating;
    assign updating = (state.phase != ph_idle);
    // ticks landing mid-update are dropped; conversions are far apart
    logic tick_taken;
    assign tick_taken = conv_tick && !updating;

    // one rise detector per command bit, judged tick to tick
    logic [15:0] cmd_rise;
    generate
        for (genvar b = 0; b < 16; b++) begin : g_rise
            assign cmd_rise[b] = rose(state.cmd_out, state.prev_cmd, b);
        end
    endgenerate

    always_comb begin
        next_state = state;
        next_state.cmd = '0;
        next_state.cmd.value = state.value_out;
        mem_wr   = 1'b0;
        mem_addr = `WORD_VALUE;
        mem_data = state.weight_snap;

        // two output words latched
        // writes land at once but act only at the next tick
        if (ctl_wr) begin
            if (ctl_wr_addr == `WORD_VALUE) begin
                next_state.value_out = ctl_wr_data;
            end else begin
                next_state.cmd_out = ctl_wr_data & `CMD_USED_MASK;
            end
        end

        // word 0 then word 1; not atomic, so busy guards both beats
        case (state.phase)
            ph_idle: begin
                if (tick_taken) begin
                    next_state.phase = ph_write_value;
                    next_state.prev_cmd = state.cmd_out;
                    next_state.weight_snap = weight_word(scale,
                        state.cmd_out[`CMD_SEL_HI:`CMD_SEL_LO], data_ok);
                    next_state.status_snap = status_word(scale,
                        discrete_input_level, data_ok);

                    if (cmd_rise[`CMD_LOAD_TARE]
                        && !tare_blocked(scale)) begin
                        next_state.cmd.load_tare = 1'b1;
                    end
                    next_state.cmd.clear_tare =
                        cmd_rise[`CMD_CLR_TARE]
                        && clear_allowed(scale);
                    next_state.cmd.pushbutton_tare =
                        cmd_rise[`CMD_PB_TARE]
                        && !tare_blocked(scale);
                    next_state.cmd.print =
                        cmd_rise[`CMD_PRINT];
                    next_state.cmd.zero =
                        cmd_rise[`CMD_ZERO];

                    // load target, commit if enabled
                    // a fresh load supersedes any pending commit
                    if (cmd_rise[`CMD_LOAD_SP1]) begin
                        next_state.cmd.load_target = 1'b1;
                        if (state.cmd_out[`CMD_ENABLE_SP]) begin
                            next_state.cmd.commit_target = 1'b1;
                            next_state.target_pending = 1'b0;
                        end else begin
                            next_state.target_pending = 1'b1;
                        end
                    end else if (state.target_pending &&
                        cmd_rise[`CMD_ENABLE_SP])
                    begin
                        next_state.cmd.commit_target = 1'b1;
                        next_state.target_pending = 1'b0;
                    end

                    next_state.hi_en = state.cmd_out[`CMD_ENABLE_SP];
                    if (scale.indicator_mode) begin
                        next_state.par =
                            state.cmd_out[`CMD_PAR_HI:`CMD_PAR_LO];
                    end
                end
            end
            ph_write_value: begin
                mem_wr   = 1'b1;
                mem_addr = `WORD_VALUE;
                mem_data = state.weight_snap;
                next_state.phase = ph_write_status;
            end
            ph_write_status: begin
                mem_wr   = 1'b1;
                mem_addr = `WORD_CMD;
                mem_data = state.status_snap;
                next_state.phase = ph_idle;
            end
            default: begin
                next_state.phase = ph_idle;
            end
        endcase

        next_state.rd_pending = ctl_rd;
        // memory answers one edge late; busy judged at both edges
        next_state.rd_busy = ctl_rd && updating;
        if (state.rd_pending) begin
            next_state.rd_data = mem_rd;
            if (state.rd_busy || updating) begin
                next_state.rd_data[`ST_BUSY] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
            state.phase <= ph_idle;
        end else begin
            state <= next_state;
        end
    end

    // registered read; busy bit lands in whichever word is read
    assign ctl_rd_data = state.rd_data;
    assign cmd = state.cmd;
    assign high_outputs_enable = state.hi_en;
    assign parallel_output_first  = state.par[0];
    assign parallel_output_second = state.par[1];
    assign parallel_output_third  = state.par[2];

    exchange_mem u_mem (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .wr_en   (mem_wr),
        .wr_addr (mem_addr),
        .wr_data (mem_data),
        .rd_addr (ctl_rd_addr),
        .rd_data (mem_rd)
    );

endmodule : scale_discrete_quarter_rack_exchange

// ### testbench/scale_exchange_assertions.sv
`timescale 1ns/1ns
module scale_exchange_checker (
    // clock and reset
    input wire logic                             mclk,
    input wire logic                             rst_n,
    // watched ports
    input wire logic                             ctl_rd,
    input wire logic [15:0]                      ctl_rd_data,
    input wire logic                             conv_tick,
    input wire scale_exchange_pkg::scale_state_s scale,
    input wire scale_exchange_pkg::scale_cmd_s   cmd,
    input wire logic                             high_outputs_enable,
    input wire logic                             parallel_output_first,
    input wire logic                             parallel_output_second,
    input wire logic                             parallel_output_third
);
    import scale_exchange_pkg::*;
    logic [2:0] par;
    assign par = {parallel_output_third, parallel_output_second,
                  parallel_output_first};

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_cmd_on_tick: assert property (|cmd[22:16] |-> $past(conv_tick))
        else $error("command pulse without a conversion tick");
    chk_print_single: assert property (cmd.print |=> !cmd.print)
        else $error("print pulse longer than one cycle");
    chk_gate_hold: assert property (
        !conv_tick |=> $stable(high_outputs_enable))
        else $error("output gate moved without a tick");
    chk_par_hold: assert property (
        !conv_tick || !scale.indicator_mode |=> $stable(par))
        else $error("parallel outputs moved outside indicator tick");
    chk_busy_read: assert property (
        ctl_rd && ($past(conv_tick) || $past(conv_tick, 2))
        |-> ##2 ctl_rd_data[14])
        else $error("read during update without busy bit");
    chk_commit_enabled: assert property (
        cmd.commit_target |-> high_outputs_enable)
        else $error("commit while setpoint enable is low");
    chk_clear_lock: assert property (
        cmd.clear_tare && $past(scale.interlocks) |-> $past(scale.gross_zero))
        else $error("interlocked clear away from gross zero");
    chk_tare_lock: assert property (
        (cmd.load_tare || cmd.pushbutton_tare) && $past(scale.interlocks)
        |-> $past(scale.tare) == 16'h0000)
        else $error("interlocked tare stacked on existing tare");

    cover property (cmd.load_target);
    cover property (cmd.commit_target);
    cover property (ctl_rd ##2 ctl_rd_data[14]);
endmodule : scale_exchange_checker

bind scale_discrete_quarter_rack_exchange scale_exchange_checker chk_i (
    .mclk, .rst_n, .ctl_rd, .ctl_rd_data, .conv_tick, .scale, .cmd,
    .high_outputs_enable, .parallel_output_first, .parallel_output_second,
    .parallel_output_third
);

// ### testbench/plc_scanner.sv
`timescale 1ns/1ns
module plc_scanner (
    // clock
    input  wire logic        mclk,
    // exchange port
    output logic             ctl_wr,
    output logic             ctl_wr_addr,
    output logic      [15:0] ctl_wr_data,
    output logic             ctl_rd,
    output logic             ctl_rd_addr,
    input  wire logic [15:0] ctl_rd_data
);
    initial begin
        ctl_wr = 1'h0;
        ctl_wr_addr = 1'h0;
        ctl_wr_data = 16'h0000;
        ctl_rd = 1'h0;
        ctl_rd_addr = 1'h0;
    end

    task automatic write_word(input logic a, input logic [15:0] w);
        @(posedge mclk) #1;
        ctl_wr = 1'h1;
        ctl_wr_addr = a;
        ctl_wr_data = w;
        @(posedge mclk) #1;
        ctl_wr = 1'h0;
        // stale data must not look valid
        ctl_wr_data = ~w;
    endtask : write_word

    task automatic read_word(input logic a, input logic retry,
                             output logic [15:0] w);
        int n;
        n = 0;
        do begin
            @(posedge mclk) #1;
            ctl_rd = 1'h1;
            ctl_rd_addr = a;
            @(posedge mclk) #1;
            ctl_rd = 1'h0;
            @(posedge mclk) #1;
            @(posedge mclk) #1;
            w = ctl_rd_data;
            n++;
        end while (retry && w[14] === 1'h1 && n < 8);
    endtask : read_word
endmodule : plc_scanner

// ### testbench/scale_discrete_quarter_rack_exchange_test.sv
`timescale 1ns/1ns
module scale_discrete_quarter_rack_exchange_test;
    import scale_exchange_pkg::*;
    logic         mclk, rst_n, conv_tick, discrete_input_level, ctl_wr;
    logic         ctl_wr_addr, ctl_rd, ctl_rd_addr, high_outputs_enable;
    logic         parallel_output_first, parallel_output_second;
    logic         parallel_output_third;
    logic  [15:0] ctl_wr_data, ctl_rd_data, v, d;
    logic  [22:0] c;
    logic [127:0] r;
    scale_state_s scale;
    scale_cmd_s   cmd;
    int           seed, fail_count, cmp_count, cycles;
    logic  [15:0] masks[6] = '{16'h0008, 16'h0010, 16'h0020, 16'h0040,
                               16'h0080, 16'h8000};
    logic   [6:0] pulses[6] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02};

    scale_discrete_quarter_rack_exchange DUT (
        .mclk, .rst_n, .ctl_wr, .ctl_wr_addr, .ctl_wr_data, .ctl_rd,
        .ctl_rd_addr, .ctl_rd_data, .conv_tick, .scale,
        .discrete_input_level, .cmd, .high_outputs_enable,
        .parallel_output_first, .parallel_output_second,
        .parallel_output_third
    );
    plc_scanner scanner (
        .mclk, .ctl_wr, .ctl_wr_addr, .ctl_wr_data, .ctl_rd, .ctl_rd_addr,
        .ctl_rd_data
    );

    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end

    function automatic logic valid(scale_state_s s);
        return !(s.over_range | s.under_range | s.powering_up | s.expanded
                 | s.setup);
    endfunction : valid

    function automatic logic [15:0] exp_weight(scale_state_s s,
                                               logic [2:0] sel);
        logic [15:0] w;
        case (sel)
            3'h1: w = s.net;
            3'h2: w = s.displayed;
            3'h3: w = s.over_under_mode ? s.target : s.tare;
            3'h4: w = s.target;
            default: w = s.gross;
        endcase
        return valid(s) ? w : 16'h0000;
    endfunction : exp_weight

    function automatic logic [15:0] exp_status(scale_state_s s, logic din);
        logic ou;
        ou = s.over_under_mode;
        return {valid(s), 1'h0, s.net_mode, s.motion, 2'h0, din, 6'h00,
                ou ? s.over_state : s.ztol_state,
                ou ? s.ok_state : s.sp2_state,
                ou ? s.under_state : s.sp1_state};
    endfunction : exp_status

    task automatic check(string name, logic [22:0] e, logic [22:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask : check

    task automatic tick();
        // let the previous update finish; mid-update ticks are dropped
        repeat (2) @(posedge mclk);
        @(posedge mclk) #1;
        conv_tick = 1'h1;
        @(posedge mclk) #1;
        conv_tick = 1'h0;
        c = cmd;
    endtask : tick

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        seed = 32'h4C8F;
        rst_n = 1'h0;
        conv_tick = 1'h0;
        discrete_input_level = 1'h0;
        scale = '0;
        repeat (5) @(posedge mclk);
        #1 rst_n = 1'h1;
        for (int i = 0; i < 16; i++) begin
            r = {$random(seed), $random(seed), $random(seed), $random(seed)};
            scale = r[96:0];
            // first half valid, second half mostly out of range
            if (i < 8) scale.over_range = 1'h0;
            if (i < 8) scale.powering_up = 1'h0;
            if (i < 8) {scale.under_range, scale.expanded, scale.setup} = 3'h0;
            discrete_input_level = r[100];
            // unused bits 9..11 set on purpose
            scanner.write_word(1'h1, {7'h07, 6'h00, i[2:0]});
            tick();
            tick();
            repeat (3) @(posedge mclk);
            scanner.read_word(1'h0, 1'h0, d);
            check("weight", 23'(exp_weight(scale, i[2:0])), 23'(d));
            scanner.read_word(1'h1, 1'h1, d);
            check("status", 23'(exp_status(scale, r[100])), 23'(d));
        end
        scale = '0;
        for (int lk = 0; lk < 3; lk++) begin
            // last pass: interlocked, no standing tare, gross at zero
            scale.interlocks = (lk != 0);
            scale.gross_zero = (lk == 2);
            scale.tare = (lk == 2) ? 16'h0000 : 16'h0010;
            for (int k = 0; k < 6; k++) begin
                v = 16'($random(seed));
                scanner.write_word(1'h0, v);
                scanner.write_word(1'h1, 16'h0E00);
                tick();
                scanner.write_word(1'h1, masks[k] | 16'h0E00);
                tick();
                // tare commands refused only on the middle pass
                check("pulse", {(lk == 1 && k < 3) ? 7'h00 : pulses[k],
                      v}, c);
                tick();
                check("again", 23'h0, {c[22:16], 16'h0000});
            end
        end
        scanner.write_word(1'h1, 16'h8100);
        tick();
        check("commit", 23'h3, {21'h0, c[16], high_outputs_enable});
        scanner.write_word(1'h1, 16'h7000);
        for (int m = 0; m < 2; m++) begin
            scale.indicator_mode = m[0];
            tick();
            check("gate", 23'h0, 23'(high_outputs_enable));
            check("par", m ? 23'h7 : 23'h0, {20'h0, parallel_output_third,
                  parallel_output_second, parallel_output_first});
        end
        tick();
        scanner.read_word(1'h1, 1'h0, d);
        check("busy", 23'h1, 23'(d[14]));
        report_and_stop();
    end
endmodule : scale_discrete_quarter_rack_exchange_test
